// ===== hw/vpc_defs.svh
`ifndef VPC_DEFS_SVH
`define VPC_DEFS_SVH

// ****************************************
// Serial link addressing
// ****************************************
`define VPC_DEV_ADDR     7'h6E
`define VPC_DIR_READ     1'b1
`define VPC_ACK_LEVEL    1'b0

// ****************************************
// Device register map
// ****************************************
`define VPC_NUM_REGS     16
`define VPC_REG_DAC1     4'h4
`define VPC_REG_DAC4     4'h7
`define VPC_REG_GLOBAL   4'h9
`define VPC_REG_STEP     4'hA
`define VPC_BIT_BLANK    0
`define VPC_BIT_STAGEOFF 1
`define VPC_BIT_HALF     3
`define VPC_BIT_BRIGHT   4
`define VPC_BIT_HOLD     0
// Reset values, register 0F down to 00
`define VPC_RST_REGS {8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h15, \
                      8'h80, 8'h80, 8'h80, 8'h80, 8'h60, 8'h60, 8'h60, 8'h60}

// ****************************************
// Controller Avalon-MM registers
// ****************************************
`define VPC_AV_CMD       4'h0
`define VPC_AV_REGADDR   4'h4
`define VPC_AV_WDATA     4'h8
`define VPC_AV_STATUS    4'hC
`define VPC_OP_NONE      2'h0
`define VPC_OP_WRITE     2'h1
`define VPC_OP_SETADDR   2'h2
`define VPC_OP_READ      2'h3

// ****************************************
// Timing
// ****************************************
`define VPC_SYS_CLK_NS   25
`define VPC_SCL_NS       10000
`define VPC_QTR_CYC      ((`VPC_SCL_NS / 4) / `VPC_SYS_CLK_NS)

`endif

// ===== hw/vpc_pkg.sv
package vpc_pkg;

    typedef enum {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_RACK} vpc_dev_st_e;
    typedef enum {BK_ADDR, BK_REG, BK_DATA} vpc_byte_e;
    typedef enum {HS_IDLE, HS_START, HS_BIT, HS_STOP} vpc_host_st_e;

    typedef struct packed {
        vpc_dev_st_e      st;
        vpc_byte_e        kind;
        logic             rw;
        logic [3:0]       cnt;
        logic [7:0]       sh;
        logic [7:0]       ptr;
        logic             sda_oe_b;
        logic             scl_p;
        logic             sda_p;
        logic [15:0][7:0] regs;
        logic [2:0][7:0]  dac;
        logic [7:0]       dac4;
        logic             blank;
        logic             stage_off;
    } vpc_dev_s;

    typedef struct packed {
        vpc_host_st_e st;
        logic [15:0]  q;
        logic [1:0]   ph;
        logic [1:0]   idx;
        logic [3:0]   bc;
        logic [1:0]   op;
        logic [8:0]   sh;
        logic [8:0]   rx;
        logic         scl;
        logic         sda_oe_b;
        logic         busy;
        logic         nack;
        logic [7:0]   rdata;
        logic [7:0]   regaddr;
        logic [7:0]   wdata;
        logic         ack;
        logic [31:0]  rdq;
    } vpc_host_s;

endpackage

// ===== hw/vpc_if.sv
`timescale 1ns/100ps
interface vpc_if;
    logic scl_m_o;
    logic scl_m_oe_b;
    logic sda_m_o;
    logic sda_m_oe_b;
    logic sda_s_o;
    logic sda_s_oe_b;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups
    assign scl = ~(~scl_m_oe_b & ~scl_m_o);
    assign sda = ~((~sda_m_oe_b & ~sda_m_o) | (~sda_s_oe_b & ~sda_s_o));

    modport master (output scl_m_o, output scl_m_oe_b, output sda_m_o, output sda_m_oe_b, input scl, input sda);
    modport slave  (output sda_s_o, output sda_s_oe_b, input scl, input sda);
endinterface

// ===== hw/vpc_sync.sv
`timescale 1ns/100ps
module vpc_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] m;
        logic [W-1:0] q;
    } vpc_sync_s;

    vpc_sync_s r;
    vpc_sync_s n;

    always_comb begin
        n   = r;
        n.m = d_i;
        n.q = r.m;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= {RST_VAL, RST_VAL};
        end else begin
            r <= n;
        end
    end

    assign q_o = r.q;
endmodule // vpc_sync

// ===== hw/vpc_host.sv
`timescale 1ns/100ps
`include "vpc_defs.svh"
module vpc_host #(
    parameter logic [15:0] QTR_CYC = 16'(`VPC_QTR_CYC)
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    vpc_if.master            bus_if,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o
);
    localparam vpc_pkg::vpc_host_s RST = '{st: vpc_pkg::HS_IDLE, scl: 1'b1, sda_oe_b: 1'b1, default: '0};

    vpc_pkg::vpc_host_s r;
    vpc_pkg::vpc_host_s n;
    logic               sda_s;
    logic               req;
    logic               tick;
    logic               rx_byte;
    logic [1:0]         last;

    vpc_sync #(.W(1), .RST_VAL(1'b1)) u_sda_sync (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       (bus_if.sda),
        .q_o       (sda_s)
    );

    function automatic logic [7:0] tx_byte(input logic [1:0] idx, input vpc_pkg::vpc_host_s s);
        if (idx == 2'h0) begin
            tx_byte = {`VPC_DEV_ADDR, s.op == `VPC_OP_READ};
        end else if (idx == 2'h1) begin
            tx_byte = (s.op == `VPC_OP_READ) ? 8'hFF : s.regaddr;
        end else begin
            tx_byte = s.wdata;
        end
    endfunction

    assign req     = avs_read_i | avs_write_i;
    assign tick    = (r.q == QTR_CYC - 16'h0001);
    assign rx_byte = (r.op == `VPC_OP_READ) && (r.idx == 2'h1);
    assign last    = (r.op == `VPC_OP_WRITE) ? 2'h2 : 2'h1;

    always_comb begin
        n     = r;
        n.ack = req & ~r.ack;
        // ****************************************
        // Avalon-MM slave
        // ****************************************
        if (req && !r.ack) begin
            if (avs_address_i == `VPC_AV_STATUS) begin
                n.rdq = {16'h0000, r.rdata, 6'h00, r.nack, r.busy};
            end else if (avs_address_i == `VPC_AV_REGADDR) begin
                n.rdq = {24'h000000, r.regaddr};
            end else if (avs_address_i == `VPC_AV_WDATA) begin
                n.rdq = {24'h000000, r.wdata};
            end else begin
                n.rdq = 32'h00000000;
            end
        end
        if (avs_write_i && r.ack) begin
            if (avs_address_i == `VPC_AV_REGADDR) begin
                n.regaddr = avs_writedata_i[7:0];
            end else if (avs_address_i == `VPC_AV_WDATA) begin
                n.wdata = avs_writedata_i[7:0];
            end else if (avs_address_i == `VPC_AV_CMD && !r.busy && avs_writedata_i[1:0] != `VPC_OP_NONE) begin
                n.op   = avs_writedata_i[1:0];
                n.busy = 1'b1;
                n.nack = 1'b0;
                n.st   = vpc_pkg::HS_START;
                n.q    = 16'h0000;
                n.ph   = 2'h0;
            end
        end
        // ****************************************
        // Bit engine, four quarters per bit
        // ****************************************
        if (r.st != vpc_pkg::HS_IDLE) begin
            n.q = tick ? 16'h0000 : r.q + 16'h0001;
        end
        case (r.st)
            vpc_pkg::HS_START: if (tick) begin
                if (r.ph == 2'h0) begin
                    n.sda_oe_b = 1'b0;
                    n.ph       = 2'h1;
                end else begin
                    n.scl = 1'b0;
                    n.ph  = 2'h0;
                    n.st  = vpc_pkg::HS_BIT;
                    n.idx = 2'h0;
                    n.bc  = 4'h0;
                    n.sh  = {tx_byte(2'h0, r), 1'b1};
                end
            end
            vpc_pkg::HS_BIT: if (tick) begin
                n.ph = r.ph + 2'h1;
                if (r.ph == 2'h0) begin
                    n.sda_oe_b = r.sh[8];
                end else if (r.ph == 2'h1) begin
                    n.scl = 1'b1;
                end else if (r.ph == 2'h2) begin
                    n.rx = {r.rx[7:0], sda_s};
                end else begin
                    n.scl = 1'b0;
                    n.sh  = {r.sh[7:0], 1'b1};
                    n.bc  = r.bc + 4'h1;
                    if (r.bc == 4'h8) begin
                        n.bc = 4'h0;
                        if (!rx_byte && r.rx[0] != `VPC_ACK_LEVEL) begin
                            n.nack = 1'b1;
                            n.st   = vpc_pkg::HS_STOP;
                        end else if (r.idx == last) begin
                            if (rx_byte) begin
                                n.rdata = r.rx[8:1];
                            end
                            n.st = vpc_pkg::HS_STOP;
                        end else begin
                            n.idx = r.idx + 2'h1;
                            n.sh  = {tx_byte(r.idx + 2'h1, r), 1'b1};
                        end
                    end
                end
            end
            vpc_pkg::HS_STOP: if (tick) begin
                n.ph = r.ph + 2'h1;
                if (r.ph == 2'h0) begin
                    n.sda_oe_b = 1'b0;
                end else if (r.ph == 2'h1) begin
                    n.scl = 1'b1;
                end else begin
                    n.sda_oe_b = 1'b1;
                    n.st       = vpc_pkg::HS_IDLE;
                    n.busy     = 1'b0;
                    n.ph       = 2'h0;
                end
            end
            default: begin
                n.q = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    assign avs_waitrequest_o = req & ~r.ack;
    assign avs_readdata_o    = r.rdq;
    assign bus_if.scl_m_o    = 1'b0;
    assign bus_if.scl_m_oe_b = r.scl;
    assign bus_if.sda_m_o    = 1'b0;
    assign bus_if.sda_m_oe_b = r.sda_oe_b;
endmodule // vpc_host

// ===== hw/vpc_preamp_dev.sv
//
// Functional notes
// - Master opens with start: data falls, clock high
// - Address byte: seven bits plus direction bit
// - Receiver pulls data low in acknowledge slot; host releases data in the slot after its read byte
// - Write: register address, then data bytes
// - Hold bit clear: data bytes advance address
// - Read preceded by address-only write, then stop
// - Read returns from stored address, advancing
// - Acknowledge bit follows every read byte
// - Global bit 0 blanks video completely
// - Global bit 1 shuts output stage off
// - Global bit 3 halves DAC 1-3 range
// - Global bit 4 adds half DAC 4
// - Flyback input forces video blanking
// - Logic blanking source gives positive pulse
//
`timescale 1ns/100ps
`include "vpc_defs.svh"
module vpc_preamp_dev (
    input  wire logic            sys_clk_i,
    input  wire logic            rst_b_i,
    vpc_if.slave                 bus_if,
    input  wire logic            flyback_i,
    output logic                 video_blank_o,
    output logic                 output_stage_off_o,
    output logic      [2:0][7:0] dac_rgb_o,
    output logic      [7:0]      dac4_o
);
    localparam vpc_pkg::vpc_dev_s RST = '{
        st:        vpc_pkg::DS_IDLE,
        kind:      vpc_pkg::BK_ADDR,
        rw:        1'b0,
        cnt:       4'h0,
        sh:        8'h00,
        ptr:       8'h00,
        sda_oe_b:  1'b1,
        scl_p:     1'b1,
        sda_p:     1'b1,
        regs:      `VPC_RST_REGS,
        dac:       '0,
        dac4:      8'h00,
        blank:     1'b0,
        stage_off: 1'b0
    };

    vpc_pkg::vpc_dev_s r;
    vpc_pkg::vpc_dev_s n;

    logic            scl_s;
    logic            sda_s;
    logic            fly_s;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_det;
    logic            stop_det;
    logic            in_map;
    logic [7:0]      rd_byte;
    logic [7:0]      global_reg;
    logic            video_blank_enable;
    logic            output_stage_shutdown;
    logic            dac_half_range_select;
    logic            brightness_offset_add;
    logic            address_step_hold;
    logic [2:0][7:0] dac_mix;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    vpc_sync #(.W(3), .RST_VAL(3'h3)) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       ({flyback_i, bus_if.scl, bus_if.sda}),
        .q_o       ({fly_s, scl_s, sda_s})
    );

    assign scl_rise  = !r.scl_p && scl_s;
    assign scl_fall  = r.scl_p && !scl_s;
    assign start_det = r.scl_p && scl_s && r.sda_p && !sda_s;
    assign stop_det  = r.scl_p && scl_s && !r.sda_p && sda_s;
    assign in_map    = (r.ptr < 8'(`VPC_NUM_REGS));
    assign rd_byte   = in_map ? r.regs[r.ptr[3:0]] : 8'h00;

    // ****************************************
    // Control bits
    // ****************************************
    assign global_reg            = r.regs[`VPC_REG_GLOBAL];
    assign video_blank_enable    = global_reg[`VPC_BIT_BLANK];
    assign output_stage_shutdown = global_reg[`VPC_BIT_STAGEOFF];
    assign dac_half_range_select = global_reg[`VPC_BIT_HALF];
    assign brightness_offset_add = global_reg[`VPC_BIT_BRIGHT];
    assign address_step_hold     = r.regs[`VPC_REG_STEP][`VPC_BIT_HOLD];

    // ****************************************
    // DAC 1-3 mixing
    // ****************************************
    for (genvar i = 0; i < 3; i++) begin : g_dac
        logic [7:0] base;
        logic [7:0] offs;
        logic [8:0] sum;
        assign base = dac_half_range_select ? {1'b0, r.regs[`VPC_REG_DAC1 + 4'(i)][7:1]}
                                            : r.regs[`VPC_REG_DAC1 + 4'(i)];
        assign offs = brightness_offset_add ? {1'b0, r.regs[`VPC_REG_DAC4][7:1]} : 8'h00;
        assign sum  = {1'b0, base} + {1'b0, offs};
        // Saturate rather than wrap to keep the level monotonic
        assign dac_mix[i] = sum[8] ? 8'hFF : sum[7:0];
    end

    always_comb begin
        n       = r;
        n.scl_p = scl_s;
        n.sda_p = sda_s;
        // ****************************************
        // Serial slave
        // ****************************************
        if (start_det) begin
            n.st       = vpc_pkg::DS_RX;
            n.kind     = vpc_pkg::BK_ADDR;
            n.cnt      = 4'h0;
            n.sda_oe_b = 1'b1;
        end else if (stop_det) begin
            n.st       = vpc_pkg::DS_IDLE;
            n.sda_oe_b = 1'b1;
        end else begin
            case (r.st)
                vpc_pkg::DS_RX: begin
                    if (scl_rise) begin
                        n.sh  = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == 4'h8) begin
                        n.sda_oe_b = 1'b0;
                        n.st       = vpc_pkg::DS_ACK;
                        case (r.kind)
                            vpc_pkg::BK_ADDR: begin
                                if (r.sh[7:1] == `VPC_DEV_ADDR) begin
                                    n.rw   = r.sh[0];
                                    n.kind = vpc_pkg::BK_REG;
                                end else begin
                                    n.sda_oe_b = 1'b1;
                                    n.st       = vpc_pkg::DS_IDLE;
                                end
                            end
                            vpc_pkg::BK_REG: begin
                                n.ptr  = r.sh;
                                n.kind = vpc_pkg::BK_DATA;
                            end
                            default: begin
                                if (in_map) begin
                                    n.regs[r.ptr[3:0]] = r.sh;
                                end
                                if (!address_step_hold) begin
                                    n.ptr = r.ptr + 8'h01;
                                end else begin
                                    n.ptr = r.ptr;
                                end
                            end
                        endcase
                    end
                end
                vpc_pkg::DS_ACK: begin
                    if (scl_fall) begin
                        if (r.rw == `VPC_DIR_READ) begin
                            n.sh       = rd_byte;
                            n.ptr      = r.ptr + 8'h01;
                            n.sda_oe_b = rd_byte[7];
                            n.cnt      = 4'h0;
                            n.st       = vpc_pkg::DS_TX;
                        end else begin
                            n.sda_oe_b = 1'b1;
                            n.cnt      = 4'h0;
                            n.st       = vpc_pkg::DS_RX;
                        end
                    end
                end
                vpc_pkg::DS_TX: begin
                    if (scl_fall) begin
                        if (r.cnt == 4'h7) begin
                            n.sda_oe_b = 1'b1;
                            n.st       = vpc_pkg::DS_RACK;
                        end else begin
                            n.sh       = {r.sh[6:0], 1'b0};
                            n.sda_oe_b = r.sh[6];
                            n.cnt      = r.cnt + 4'h1;
                        end
                    end
                end
                vpc_pkg::DS_RACK: begin
                    if (scl_rise) begin
                        n.sh[0] = sda_s;
                    end else if (scl_fall) begin
                        if (r.sh[0] == `VPC_ACK_LEVEL) begin
                            n.sh       = rd_byte;
                            n.ptr      = r.ptr + 8'h01;
                            n.sda_oe_b = rd_byte[7];
                            n.cnt      = 4'h0;
                            n.st       = vpc_pkg::DS_TX;
                        end else begin
                            n.st = vpc_pkg::DS_IDLE;
                        end
                    end
                end
                default: begin
                    n.sda_oe_b = 1'b1;
                end
            endcase
        end
        // ****************************************
        // Video outputs
        // ****************************************
        n.blank     = video_blank_enable | fly_s;
        n.stage_off = output_stage_shutdown;
        n.dac       = dac_mix;
        n.dac4      = r.regs[`VPC_REG_DAC4];
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bus_if.sda_s_o     = 1'b0;
    assign bus_if.sda_s_oe_b  = r.sda_oe_b;
    assign video_blank_o      = r.blank;
    assign output_stage_off_o = r.stage_off;
    assign dac_rgb_o          = r.dac;
    assign dac4_o             = r.dac4;
endmodule // vpc_preamp_dev

// ===== dv/vpc_link_props.sv
`timescale 1ns/100ps
module vpc_link_props (
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic scl_m_o,
    input  wire logic sda_m_o,
    input  wire logic sda_m_oe_b,
    input  wire logic sda_s_o,
    input  wire logic sda_s_oe_b,
    input  wire logic scl,
    input  wire logic sda
);
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q;
    logic       rw_q;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence start_s; scl && $fell(sda); endsequence
    sequence stop_s; scl && $rose(sda); endsequence
    sequence rise_s; $rose(scl); endsequence

    // ****************************************
    // Bit and byte position since last start
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_q  <= 4'h0;
            byte_q <= 2'h0;
            sh_q   <= 8'h00;
            rw_q   <= 1'b0;
        end else if (scl && $fell(sda)) begin
            bit_q  <= 4'h0;
            byte_q <= 2'h0;
        end else if ($rose(scl)) begin
            sh_q <= {sh_q[6:0], sda};
            if (bit_q == 4'h8) begin
                bit_q  <= 4'h0;
                byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
            end else begin
                bit_q <= bit_q + 4'h1;
            end
            if (bit_q == 4'h7 && byte_q == 2'h0) begin
                rw_q <= sda;
            end
        end
    end

    a_open_drain_low: assert property (!sda_s_o && !sda_m_o && !scl_m_o)
        else $error("driven data level not low");
    a_no_contention: assert property ((scl && !sda_s_oe_b) |-> sda_m_oe_b)
        else $error("both ends pull data");
    a_start_released: assert property (start_s |-> sda_s_oe_b)
        else $error("device pulls data at start");
    a_stop_to_idle: assert property (stop_s |=> sda_s_oe_b [*8])
        else $error("device active after stop");
    a_addr_ack: assert property (rise_s ##0 (bit_q == 4'h8 && byte_q == 2'h0)
        |-> (!sda_s_oe_b) == (sh_q[7:1] == 7'h6E))
        else $error("address acknowledge wrong");
    a_addr_silent: assert property (rise_s ##0 (byte_q == 2'h0 && bit_q != 4'h8) |-> sda_s_oe_b)
        else $error("device drives during address");
    a_read_master_slot: assert property (rise_s ##0 (rw_q && byte_q == 2'h1 && bit_q == 4'h8) |-> sda_s_oe_b)
        else $error("device holds master slot");
    a_ack_bounded: assert property ($fell(sda_s_oe_b) |-> ##[1:400] $rose(sda_s_oe_b))
        else $error("device never releases data");
    a_slave_edge_low: assert property ($changed(sda_s_oe_b) |-> !scl)
        else $error("device data moves with clock high");
endmodule // vpc_link_props

// ===== dv/video_preamp_i2c_control_tb.sv
`timescale 1ns/100ps
`include "vpc_defs.svh"
module video_preamp_i2c_control_tb;
    logic            sys_clk_i, rst_b_i, flyback_i, avs_read_i, avs_write_i;
    logic            avs_waitrequest_o, video_blank_o, output_stage_off_o;
    logic [3:0]      avs_address_i;
    logic [31:0]     avs_writedata_i, avs_readdata_o, q;
    logic [2:0][7:0] dac_rgb_o;
    logic [7:0]      dac4_o;
    int              errors, comparisons;

    vpc_if vpc_if_i ();
    vpc_host #(.QTR_CYC(16'h0008)) vpc_host_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_if(vpc_if_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
    vpc_preamp_dev vpc_preamp_dev_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_if(vpc_if_i),
        .flyback_i(flyback_i), .video_blank_o(video_blank_o), .output_stage_off_o(output_stage_off_o),
        .dac_rgb_o(dac_rgb_o), .dac4_o(dac4_o));
    vpc_link_props vpc_link_props_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .scl_m_o(vpc_if_i.scl_m_o),
        .sda_m_o(vpc_if_i.sda_m_o), .sda_m_oe_b(vpc_if_i.sda_m_oe_b), .sda_s_o(vpc_if_i.sda_s_o),
        .sda_s_oe_b(vpc_if_i.sda_s_oe_b), .scl(vpc_if_i.scl), .sda(vpc_if_i.sda));

    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    // Runs one serial command and waits until the host is idle
    task link(input logic [1:0] op, input logic [7:0] ra, input logic [7:0] wd);
        av(1'b1, `VPC_AV_REGADDR, {24'h000000, ra});
        av(1'b1, `VPC_AV_WDATA, {24'h000000, wd});
        av(1'b1, `VPC_AV_CMD, {30'h00000000, op});
        do begin
            av(1'b0, `VPC_AV_STATUS, 32'h00000000);
        end while (q[0] !== 1'b0);
        chk({31'h00000000, q[1]}, 32'h00000000);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        chk(dac_rgb_o, 32'h00808080);
        chk({video_blank_o, output_stage_off_o}, 32'h00000000);
        av(1'b0, 4'h2, 32'h00000000);
        chk(q, 32'h00000000);
    endtask

    task t_power;
        logic [7:0] v[4] = '{8'h01, 8'h03, 8'h02, 8'h00};
        logic [1:0] e[4] = '{2'h2, 2'h3, 2'h1, 2'h0};
        for (int i = 0; i < 4; i++) begin
            link(`VPC_OP_WRITE, 8'h09, v[i]);
            chk({video_blank_o, output_stage_off_o}, e[i]);
        end
    endtask

    task t_dacs;
        logic [7:0]  v[4] = '{8'h08, 8'h10, 8'h18, 8'h00};
        logic [23:0] e[4] = '{24'h401178, 24'hC062FF, 24'h8051B8, 24'h8022F0};
        link(`VPC_OP_WRITE, 8'h04, 8'hF0);
        link(`VPC_OP_WRITE, 8'h05, 8'h22);
        for (int i = 0; i < 4; i++) begin
            link(`VPC_OP_WRITE, 8'h09, v[i]);
            chk(dac_rgb_o, e[i]);
            chk(dac4_o, 32'h00000080);
        end
    endtask

    task t_read;
        logic [7:0] e[3] = '{8'hF0, 8'h22, 8'h80};
        link(`VPC_OP_SETADDR, 8'h04, 8'h00);
        for (int i = 0; i < 3; i++) begin
            link(`VPC_OP_READ, 8'h00, 8'h00);
            chk(q[15:8], e[i]);
        end
    endtask

    task t_step;
        link(`VPC_OP_WRITE, 8'h07, 8'h40);
        chk(dac4_o, 32'h00000040);
        link(`VPC_OP_READ, 8'h00, 8'h00);
        chk(q[15:8], 32'h00000015);
        link(`VPC_OP_WRITE, 8'h0A, 8'h01);
        link(`VPC_OP_WRITE, 8'h05, 8'h44);
        link(`VPC_OP_READ, 8'h00, 8'h00);
        chk(q[15:8], 32'h00000044);
    endtask

    task t_flyback;
        @(posedge sys_clk_i);
        flyback_i <= 1'b1;
        repeat (6) @(negedge sys_clk_i);
        chk(video_blank_o, 32'h00000001);
        @(posedge sys_clk_i);
        flyback_i <= 1'b0;
        repeat (6) @(negedge sys_clk_i);
        chk(video_blank_o, 32'h00000000);
    endtask

    task tally_and_finish;
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        repeat (80000) @(posedge sys_clk_i);
        errors++;
        tally_and_finish;
    end

    initial begin
        rst_b_i         = 1'b0;
        flyback_i       = 1'b0;
        avs_read_i      = 1'b0;
        avs_write_i     = 1'b0;
        avs_address_i   = 4'h0;
        avs_writedata_i = 32'h00000000;
        errors          = 0;
        comparisons     = 0;
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (8) @(negedge sys_clk_i);
        t_reset;
        t_power;
        t_dacs;
        t_read;
        t_step;
        t_flyback;
        tally_and_finish;
    end
endmodule // video_preamp_i2c_control_tb
